/* File: core/cpu_evt_pkg.sv */
// Purpose: shared constants of the clock/power event logic
// Assumes: 8-bit register port, 10-bit byte address
// Notes:   offsets, bit positions, reset values, timing counts
package cpu_evt_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [9:0] OFS_CTRL   = 10'h2f0;
  localparam logic [9:0] OFS_FLAGS  = 10'h2f1;
  localparam logic [9:0] OFS_STATUS = 10'h2f2;
  localparam logic [9:0] OFS_RATE   = 10'h2f3;
  localparam logic [9:0] OFS_TEST   = 10'h2f6;

  // control register bits
  localparam int unsigned CTL_PERIODIC_IE = 0;
  localparam int unsigned CTL_PLL_IE      = 1;
  localparam int unsigned CTL_CRYSTAL_IE  = 2;
  localparam int unsigned CTL_LOW_IE      = 3;
  localparam int unsigned CTL_CRYSTAL_EN  = 4;
  localparam int unsigned CTL_FILTER      = 5;

  // flag register bits (write one to clear)
  localparam int unsigned FLG_PERIODIC = 0;
  localparam int unsigned FLG_PLL      = 1;
  localparam int unsigned FLG_CRYSTAL  = 2;
  localparam int unsigned FLG_LOW      = 3;

  // status register bits
  localparam int unsigned STS_LOCK     = 0;
  localparam int unsigned STS_QUAL     = 1;
  localparam int unsigned STS_LOW      = 2;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [7:0] TEST_RST = 8'h00;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned QUAL_TIME_NS  = 1000;
  localparam int unsigned QUAL_CYCLES   =
    (QUAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PRESCALE_CYCLES = 16;

  typedef enum logic [2:0] {
    XTAL_OFF  = 3'b001,
    XTAL_WAIT = 3'b010,
    XTAL_QUAL = 3'b100
  } xtal_state_t;

endpackage : cpu_evt_pkg

/* File: core/sync2.sv */
// Purpose: two-flop synchroniser for asynchronous levels
// Assumes: inputs are slow levels, not pulses
// Notes:   only the second stage leaves this module
`timescale 1ns/100ps
`default_nettype none
module sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_r;

  if (WIDTH < 1) begin : g_bad_width
    $error("sync2: WIDTH must be at least 1");
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_o <= '0;
    end else begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end
endmodule : sync2
`default_nettype wire

/* File: core/periodic_timer.sv */
// Purpose: periodic timeout generator
// Assumes: rate 0 stops the timer
// Notes:   period = (rate[3:0]+1) << rate[6:4] prescaled units
`timescale 1ns/100ps
`default_nettype none
module periodic_timer
  import cpu_evt_pkg::*;
#(
  parameter int unsigned PRESCALE = PRESCALE_CYCLES
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [7:0] rate_i,
  input  wire logic       restart_i,
  output logic            tick_o
);
  logic [15:0] pre_r;
  logic [10:0] unit_r;
  logic [10:0] last_unit;
  logic        unit_end;
  logic        period_end;

  if (PRESCALE < 1 || PRESCALE > 65536) begin : g_bad_prescale
    $error("periodic_timer: bad PRESCALE");
  end

  assign last_unit  = (11'({7'h00, rate_i[3:0]} + 11'h001) << rate_i[6:4]) - 11'h001;
  assign unit_end   = (pre_r == 16'(PRESCALE - 1));
  assign period_end = unit_end && (unit_r == last_unit);

  // next period begins on the same edge tick_o is raised
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pre_r  <= 16'h0000;
      unit_r <= 11'h000;
    end else if (restart_i || rate_i == 8'h00 || period_end) begin
      pre_r  <= 16'h0000;
      unit_r <= 11'h000;
    end else if (unit_end) begin
      pre_r  <= 16'h0000;
      unit_r <= unit_r + 11'h001;
    end else begin
      pre_r  <= pre_r + 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) tick_o <= 1'b0;
    else          tick_o <= period_end && !restart_i && rate_i != 8'h00;
  end

  a_restart_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    restart_i |=> (pre_r == 16'h0000 && unit_r == 11'h000 && !tick_o))
    else $error("timer did not restart on rate write");
endmodule : periodic_timer
`default_nettype wire

/* File: core/cpu_event_logic.sv */
// Purpose: event and status logic of the clock, reset and power unit
// Assumes: pll lock and supply comparator are asynchronous levels;
//          stop, mode and pll config inputs are on sys_clk_i
// Notes:   registers reached over a plain strobe port
`timescale 1ns/100ps
`default_nettype none
module cpu_event_logic
  import cpu_evt_pkg::*;
#(
  parameter int unsigned QUAL_CNT = QUAL_CYCLES,
  parameter int unsigned PRESCALE = PRESCALE_CYCLES
) (
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_n_i,
  input  wire logic [cpu_evt_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [cpu_evt_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                           wr_en_i,
  input  wire logic                           rd_en_i,
  output logic      [cpu_evt_pkg::DATA_W-1:0] rd_data_o,
  input  wire logic                           pll_lock_i,
  input  wire logic                           pll_cfg_change_i,
  input  wire logic                           full_stop_i,
  input  wire logic                           full_perf_mode_i,
  input  wire logic                           supply_low_i,
  input  wire logic                           special_mode_i,
  output logic                                periodic_irq_o,
  output logic                                pll_irq_o,
  output logic                                crystal_irq_o,
  output logic                                low_supply_irq_o,
  output logic                                crystal_qualified_o,
  output logic                                spike_filter_on_o
);
  import cpu_evt_pkg::*;

  if (QUAL_CNT < 1 || QUAL_CNT > 65535) begin : g_bad_qual
    $error("cpu_event_logic: bad QUAL_CNT");
  end

  // ---- register storage
  logic [7:0]  ctrl_r;
  logic [7:0]  rate_r;
  logic [7:0]  test_r;
  logic [3:0]  flags_r;
  logic [3:0]  flags_nxt;
  logic        low_status_r;
  logic        lock_prev_r;
  logic        qual_prev_r;
  logic        low_prev_r;
  logic [15:0] qual_cnt_r;
  xtal_state_t xtal_r;
  xtal_state_t xtal_nxt;

  logic [1:0]  async_s;
  logic        lock_s;
  logic        low_s;
  logic        tick;
  logic        qual;
  logic        kill;

  // one decode shared by read and write paths
  function automatic logic hit(input logic [9:0] a, input logic [9:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_ctrl;
  logic wr_flags;
  logic wr_rate;
  logic wr_test;
  assign wr_ctrl  = wr_en_i && hit(addr_i, OFS_CTRL);
  assign wr_flags = wr_en_i && hit(addr_i, OFS_FLAGS);
  assign wr_rate  = wr_en_i && hit(addr_i, OFS_RATE);
  assign wr_test  = wr_en_i && hit(addr_i, OFS_TEST);

  // ---- asynchronous inputs
  sync2 #(
    .WIDTH (2)
  ) u_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({supply_low_i, pll_lock_i}),
    .sync_o    (async_s)
  );
  assign lock_s = async_s[0];
  assign low_s  = async_s[1];

  // ---- periodic timer
  periodic_timer #(
    .PRESCALE (PRESCALE)
  ) u_timer (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .rate_i    (rate_r),
    .restart_i (wr_rate),
    .tick_o    (tick)
  );

  // ---- software registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctrl_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= {2'b00, wr_data_i[5:0]};
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rate_r <= RATE_RST;
    end else if (wr_rate) begin
      rate_r <= {1'b0, wr_data_i[6:0]};
    end
  end

  // factory test: readable always, writes outside special mode dropped
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      test_r <= TEST_RST;
    end else if (wr_test && special_mode_i) begin
      test_r <= wr_data_i;
    end
  end

  // ---- crystal qualification
  // any of these loses the qualified status at once
  assign kill = !ctrl_r[CTL_CRYSTAL_EN] || full_stop_i || !lock_s
                || pll_cfg_change_i;

  always_comb begin
    xtal_nxt = xtal_r;
    case (xtal_r)
      XTAL_OFF: begin
        if (!kill) begin
          xtal_nxt = ctrl_r[CTL_FILTER] ? XTAL_WAIT : XTAL_QUAL;
        end
      end
      XTAL_WAIT: begin
        if (kill) begin
          xtal_nxt = XTAL_OFF;
        end else if (qual_cnt_r == 16'(QUAL_CNT - 1)) begin
          xtal_nxt = XTAL_QUAL;
        end
      end
      XTAL_QUAL: begin
        if (kill) begin
          xtal_nxt = XTAL_OFF;
        end
      end
      default: begin
        xtal_nxt = XTAL_OFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) xtal_r <= XTAL_OFF;
    else          xtal_r <= xtal_nxt;
  end

  // filter settle time only counts while waiting
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      qual_cnt_r <= 16'h0000;
    end else if (xtal_r == XTAL_WAIT && !kill) begin
      qual_cnt_r <= qual_cnt_r + 16'h0001;
    end else begin
      qual_cnt_r <= 16'h0000;
    end
  end

  assign qual = (xtal_r == XTAL_QUAL);

  // ---- low supply status, set only in full performance mode, cleared on recovery in any mode
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_status_r <= 1'b0;
    end else if (full_perf_mode_i && low_s) begin
      low_status_r <= 1'b1;
    end else if (!low_s) begin
      low_status_r <= 1'b0;
    end
  end

  // ---- change detection history
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lock_prev_r <= 1'b0;
      qual_prev_r <= 1'b0;
      low_prev_r  <= 1'b0;
    end else begin
      lock_prev_r <= lock_s;
      qual_prev_r <= qual;
      low_prev_r  <= low_status_r;
    end
  end

  // ---- flags: a set in the clearing cycle wins
  logic [3:0] flag_set;
  logic [3:0] flag_clr;
  assign flag_set[FLG_PERIODIC] = tick;
  assign flag_set[FLG_PLL]      = lock_s != lock_prev_r;
  assign flag_set[FLG_CRYSTAL]  = qual != qual_prev_r;
  assign flag_set[FLG_LOW]      = (low_status_r != low_prev_r)
                                  && ctrl_r[CTL_LOW_IE];
  assign flag_clr = wr_flags ? wr_data_i[3:0] : 4'h0;

  assign flags_nxt = flag_set | (flags_r & ~flag_clr);

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) flags_r <= 4'h0;
    else          flags_r <= flags_nxt;
  end

  // ---- interrupt requests, registered from flag and enable
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      periodic_irq_o   <= 1'b0;
      pll_irq_o        <= 1'b0;
      crystal_irq_o    <= 1'b0;
      low_supply_irq_o <= 1'b0;
    end else begin
      periodic_irq_o   <= flags_r[FLG_PERIODIC] && ctrl_r[CTL_PERIODIC_IE];
      pll_irq_o        <= flags_r[FLG_PLL] && ctrl_r[CTL_PLL_IE];
      crystal_irq_o    <= flags_r[FLG_CRYSTAL] && ctrl_r[CTL_CRYSTAL_IE];
      low_supply_irq_o <= flags_r[FLG_LOW] && ctrl_r[CTL_LOW_IE];
    end
  end

  // ---- crystal outputs
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crystal_qualified_o <= 1'b0;
      spike_filter_on_o   <= 1'b0;
    end else begin
      crystal_qualified_o <= qual;
      // filter off means the clock passes unfiltered
      spike_filter_on_o   <= ctrl_r[CTL_CRYSTAL_EN] && ctrl_r[CTL_FILTER];
    end
  end

  // ---- read port, data one cycle after the strobe
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else if (rd_en_i) begin
      if (hit(addr_i, OFS_CTRL)) begin
        rd_data_o <= ctrl_r;
      end else if (hit(addr_i, OFS_FLAGS)) begin
        rd_data_o <= {4'h0, flags_r};
      end else if (hit(addr_i, OFS_STATUS)) begin
        rd_data_o <= {5'h00, low_status_r, qual, lock_s};
      end else if (hit(addr_i, OFS_RATE)) begin
        rd_data_o <= rate_r;
      end else if (hit(addr_i, OFS_TEST)) begin
        rd_data_o <= test_r;
      end else begin
        rd_data_o <= 8'h00;
      end
    end else begin
      rd_data_o <= 8'h00;
    end
  end

  // ---- checks
  a_periodic_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    tick |=> flags_r[FLG_PERIODIC])
    else $error("timeout did not set periodic flag");

  a_periodic_irq_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctrl_r[CTL_PERIODIC_IE] ##1 !ctrl_r[CTL_PERIODIC_IE] |-> !periodic_irq_o)
    else $error("periodic irq raised while disabled");

  a_lock_change_flag: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (lock_s != $past(lock_s)) |=> flags_r[FLG_PLL])
    else $error("lock change not flagged");

  a_pll_irq_follows: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pll_irq_o == $past(flags_r[FLG_PLL] && ctrl_r[CTL_PLL_IE]))
    else $error("pll irq not flag and enable");

  a_flag_write_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_flags && wr_data_i[FLG_PLL] && !flag_set[FLG_PLL]) |=> !flags_r[FLG_PLL])
    else $error("write one did not clear lock flag");

  a_flag_zero_keeps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_flags && !wr_data_i[FLG_LOW] && flags_r[FLG_LOW]) |=> flags_r[FLG_LOW])
    else $error("write zero cleared a flag");

  a_crystal_off_zero: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !ctrl_r[CTL_CRYSTAL_EN] |=> !qual ##1 !crystal_qualified_o)
    else $error("qualified while crystal disabled");

  a_qual_needs_lock: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    $rose(qual) |-> $past(lock_s) && $past(ctrl_r[CTL_CRYSTAL_EN]))
    else $error("qualified without lock");

  a_cfg_change_clears: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    pll_cfg_change_i |=> !qual)
    else $error("pll reconfig kept qualified status");

  a_crystal_flag_set: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (qual != $past(qual)) |=> flags_r[FLG_CRYSTAL])
    else $error("qualified change not flagged");

  a_low_status_clear: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !low_s |=> !low_status_r)
    else $error("low status kept after recovery");

  a_low_flag_gated: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (!ctrl_r[CTL_LOW_IE] && !flags_r[FLG_LOW]) |=> !flags_r[FLG_LOW])
    else $error("low flag set while disabled");

  a_test_write_guard: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (wr_test && !special_mode_i) |=> $stable(test_r))
    else $error("test register written outside special mode");
endmodule : cpu_event_logic
`default_nettype wire

/* File: testbench/cpu_event_logic_tb_top.sv */
// Purpose: self-checking bench for the clock/power event logic
// Assumes: short qualify and prescale counts so periodic and filter runs stay brief
// Notes:   xorshift stimulus from a fixed seed, hand-written corner cases after it
`timescale 1ns/100ps
`default_nettype none
module cpu_event_logic_tb_top;
  import cpu_evt_pkg::*;

  localparam int unsigned QCNT = 4;
  localparam int unsigned PSC  = 2;

  logic       clk      = 1'b0;
  logic       rst_n    = 1'b0;
  logic [9:0] addr     = 10'h000;
  logic [7:0] wdata    = 8'h00;
  logic       wen      = 1'b0;
  logic       ren      = 1'b0;
  logic [7:0] rdata;
  logic       pll_lock = 1'b0;
  logic       cfg_chg  = 1'b0;
  logic       stop     = 1'b0;
  logic       perf     = 1'b0;
  logic       sup_low  = 1'b0;
  logic       spec     = 1'b0;
  logic       per_irq;
  logic       pll_irq;
  logic       xtal_irq;
  logic       low_irq;
  logic       qual;
  logic       filt_on;
  int         err_count  = 0;
  int         num_checks = 0;
  logic [31:0] rs;
  logic [7:0]  d;
  logic [7:0]  v;
  int          n;
  int          m;

  always #5 clk = ~clk;

  cpu_event_logic #(.QUAL_CNT(QCNT), .PRESCALE(PSC)) i_dut (
    .sys_clk_i          (clk),
    .rst_n_i            (rst_n),
    .addr_i             (addr),
    .wr_data_i          (wdata),
    .wr_en_i            (wen),
    .rd_en_i            (ren),
    .rd_data_o          (rdata),
    .pll_lock_i         (pll_lock),
    .pll_cfg_change_i   (cfg_chg),
    .full_stop_i        (stop),
    .full_perf_mode_i   (perf),
    .supply_low_i       (sup_low),
    .special_mode_i     (spec),
    .periodic_irq_o     (per_irq),
    .pll_irq_o          (pll_irq),
    .crystal_irq_o      (xtal_irq),
    .low_supply_irq_o   (low_irq),
    .crystal_qualified_o(qual),
    .spike_filter_on_o  (filt_on)
  );

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  // unused control bits read back as zero
  function automatic logic [7:0] exp_ctrl(input logic [7:0] w);
    return {2'b00, w[5:0]};
  endfunction : exp_ctrl

  function automatic int period(input logic [7:0] r);
    return ((int'(r[3:0]) + 1) << r[6:4]) * PSC;
  endfunction : period

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [9:0] a, input logic [7:0] w);
    @(posedge clk);
    wen   <= 1'b1;
    addr  <= a;
    wdata <= w;
    @(posedge clk);
    wen   <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    @(posedge clk);
    ren  <= 1'b1;
    addr <= a;
    @(posedge clk);
    ren  <= 1'b0;
    #1;
    q = rdata;
  endtask : rd

  // always lets one edge pass, so a request still high from before is not taken
  task automatic wait_per(output int k);
    k = 0;
    do begin
      cyc(1);
      k++;
      if (k > 300) begin
        err_count++;
        final_report();
      end
    end while (per_irq !== 1'b1);
  endtask : wait_per

  initial begin
    rs = 32'd93546;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cyc(3);
    rd(OFS_CTRL, d);   chk(d, CTRL_RST);
    rd(OFS_RATE, d);   chk(d, RATE_RST);
    rd(OFS_TEST, d);   chk(d, TEST_RST);
    rd(10'h3ff, d);    chk(d, 8'h00);
    rd(OFS_STATUS, d); chk(d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      rs = xs(rs);
      v  = rs[7:0];
      wr(OFS_CTRL, v);
      rd(OFS_CTRL, d); chk(d, exp_ctrl(v));
      wr(OFS_RATE, rs[15:8]);
      rd(OFS_RATE, d); chk(d, {1'b0, rs[14:8]});
      spec <= 1'b0;
      wr(OFS_TEST, rs[23:16]);
      rd(OFS_TEST, d); chk(d, TEST_RST);
    end
    spec <= 1'b1;
    wr(OFS_TEST, rs[31:24]);
    rd(OFS_TEST, d); chk(d, rs[31:24]);
    spec <= 1'b0;
    wr(OFS_RATE, 8'h00);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_FLAGS, 8'h0f);
    // lock change with its irq masked, then enabled
    pll_lock <= 1'b1;
    cyc(6);
    rd(OFS_FLAGS, d); chk(d, 8'h02);
    chk({7'h0, pll_irq}, 8'h00);
    wr(OFS_FLAGS, 8'h00);
    rd(OFS_FLAGS, d); chk(d, 8'h02);
    wr(OFS_CTRL, 8'h01 << CTL_PLL_IE);
    cyc(2);
    chk({7'h0, pll_irq}, 8'h01);
    wr(OFS_FLAGS, 8'h01 << FLG_PLL);
    cyc(2);
    chk({7'h0, pll_irq}, 8'h00);
    pll_lock <= 1'b0;
    cyc(6);
    chk({7'h0, pll_irq}, 8'h01);
    pll_lock <= 1'b1;
    cyc(6);
    wr(OFS_FLAGS, 8'h0f);
    // crystal qualification and its status-change flag
    wr(OFS_CTRL, (8'h01 << CTL_CRYSTAL_EN) | (8'h01 << CTL_CRYSTAL_IE));
    cyc(4);
    chk({7'h0, qual}, 8'h01);
    chk({7'h0, filt_on}, 8'h00);
    chk({7'h0, xtal_irq}, 8'h01);
    wr(OFS_FLAGS, 8'h01 << FLG_CRYSTAL);
    cyc(2);
    chk({7'h0, xtal_irq}, 8'h00);
    stop <= 1'b1;
    cyc(4);
    chk({7'h0, qual}, 8'h00);
    chk({7'h0, xtal_irq}, 8'h01);
    stop <= 1'b0;
    cyc(4);
    wr(OFS_FLAGS, 8'h0f);
    cyc(1);
    cfg_chg <= 1'b1;
    @(posedge clk);
    cfg_chg <= 1'b0;
    cyc(3);
    rd(OFS_FLAGS, d); chk(d & 8'h04, 8'h04);
    pll_lock <= 1'b0;
    cyc(6);
    chk({7'h0, qual}, 8'h00);
    wr(OFS_CTRL, 8'h00);
    pll_lock <= 1'b1;
    cyc(8);
    chk({7'h0, qual}, 8'h00);
    wr(OFS_FLAGS, 8'h0f);
    // filter on: longer qualify, irq masked
    wr(OFS_CTRL, (8'h01 << CTL_CRYSTAL_EN) | (8'h01 << CTL_FILTER));
    cyc(2);
    chk({7'h0, filt_on}, 8'h01);
    cyc(QCNT + 4);
    chk({7'h0, qual}, 8'h01);
    rd(OFS_FLAGS, d); chk(d & 8'h04, 8'h04);
    chk({7'h0, xtal_irq}, 8'h00);
    // low supply status sets from comparator only in full performance, clears on recovery
    wr(OFS_CTRL, 8'h01 << CTL_LOW_IE);
    wr(OFS_FLAGS, 8'h0f);
    sup_low <= 1'b1;
    cyc(6);
    rd(OFS_STATUS, d); chk(d & 8'h04, 8'h00);
    perf <= 1'b1;
    cyc(6);
    rd(OFS_STATUS, d); chk(d & 8'h04, 8'h04);
    chk({7'h0, low_irq}, 8'h01);
    wr(OFS_FLAGS, 8'h07);
    cyc(2);
    chk({7'h0, low_irq}, 8'h01);
    wr(OFS_FLAGS, 8'h01 << FLG_LOW);
    cyc(2);
    chk({7'h0, low_irq}, 8'h00);
    sup_low <= 1'b0;
    cyc(6);
    rd(OFS_STATUS, d); chk(d & 8'h04, 8'h00);
    chk({7'h0, low_irq}, 8'h01);
    wr(OFS_CTRL, 8'h00);
    wr(OFS_FLAGS, 8'h0f);
    sup_low <= 1'b1;
    cyc(6);
    rd(OFS_FLAGS, d); chk(d & 8'h08, 8'h00);
    // periodic timer: rate, back-to-back periods, restart on rate write
    wr(OFS_CTRL, 8'h01 << CTL_PERIODIC_IE);
    wr(OFS_RATE, 8'h01);
    // irq follows the timeout by flag and request stages, two edges
    wait_per(n);
    chk(8'(n), 8'(period(8'h01) + 2));
    wr(OFS_FLAGS, 8'h01 << FLG_PERIODIC);
    wait_per(m);
    // the clearing write spans two edges; any gap between periods shows here
    chk(8'(n + 2 + m), 8'(2 * period(8'h01) + 2));
    wr(OFS_RATE, 8'h03);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_FLAGS, 8'h01 << FLG_PERIODIC);
      wr(OFS_RATE, 8'h03);
    end
    rd(OFS_FLAGS, d); chk(d & 8'h01, 8'h00);
    wr(OFS_CTRL, 8'h00);
    cyc(period(8'h03) + 6);
    chk({7'h0, per_irq}, 8'h00);
    rd(OFS_FLAGS, d); chk(d & 8'h01, 8'h01);
    wr(OFS_RATE, 8'h00);
    final_report();
  end
endmodule : cpu_event_logic_tb_top
`default_nettype wire
